// file: inc/sas_pkg.sv
// package for the converter sequencer: offsets, fields, timing
// ==========================================================
// Overview of operation
// RL1: trigger_control_reg is 8 bits, r/w, resets and standby to 7f.
// RL2: bit 7 is ext_trigger_enable; 0 no external start, 1 illegal.
// RL3: bits 6..0 of trigger_control_reg are read-only and read as 1.
// RL4: reading a result high byte returns it and latches the low byte.
// RL5: reading a result low byte returns the holding register.
// RL6: software reads high byte before low byte; low alone may be stale.
// RL7: 10-bit successive approximation with single and scan modes.
// RL8: single mode: start runs one conversion, start self-clears at end.
// RL9: single end sets end flag; irq raised if irq enable set.
// RL10: end flag clears only by read of status then write of 0.
// RL11: software clears start before changing mode or channel.
// RL12: each result goes to the register of the converted channel.
// RL13: scan starts at channel 0, steps through group, repeats.
// RL14: scan group done sets end flag, restarts at 0, irq if enabled.
// RL15: scan restart after start cleared begins at first channel.
// RL16: sync delay 10..17 states slow, 6..9 states fast.
// RL17: total time includes sync delay and 80 or 40 state sampling.
// RL18: first conversion 259..266 states slow, 131..134 fast.
// RL19: later scan conversions exactly 256 or 128 states.
// RL20: result high byte holds bits 9..2, low bits 7..6 hold 1..0.
// RL21: channel code picks channel or group; top bit set illegal.
// RL22: channels 0..3 map to result registers a..d.
// RL23: status layout: flag, irq en, start, scan, clock sel, channel.
// RL24: analog part is external: sample strobe, channel, 10-bit result.
// RL25: ext trigger enable is stored but conversions stay software-only.
package sas_pkg;
    // byte offsets of the register window
    localparam logic [3:0] OFS_RES_A_HI = 4'h0;
    localparam logic [3:0] OFS_STATUS   = 4'h8;
    localparam logic [3:0] OFS_TRIGGER  = 4'h9;
    // reset values
    localparam logic [7:0] TRIG_RESET   = 8'h7f;
    localparam logic [7:0] TRIG_RO_ONES = 8'h7f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // status and trigger field positions
    localparam int B_FLAG  = 7;
    localparam int B_IRQEN = 6;
    localparam int B_START = 5;
    localparam int B_SCAN  = 4;
    localparam int B_CKS   = 3;
    localparam int B_EXT_TRIGGER_ENABLE  = 7;
    // timing in states: fixed sync delays, sample and step periods
    localparam int SYNC_SLOW   = 10;
    localparam int SYNC_FAST   = 6;
    localparam int SAMPLE_SLOW = 80;
    localparam int SAMPLE_FAST = 40;
    localparam int CONV_SLOW   = 256;
    localparam int CONV_FAST   = 128;
    // first conversion totals and the slowest sync delays allowed
    localparam int FIRST_SLOW     = 259;
    localparam int FIRST_FAST     = 131;
    localparam int FIRST_SLOW_MAX = 266;
    localparam int FIRST_FAST_MAX = 134;
    localparam int SYNC_SLOW_MAX  = 17;
    localparam int SYNC_FAST_MAX  = 9;
    localparam int RES_W       = 10;
    typedef enum logic [1:0] {
        SAS_IDLE = 2'b00,
        SAS_SYNC = 2'b01,
        SAS_CONV = 2'b10
    } sas_state_t;
endpackage : sas_pkg

// file: rtl/sas_result_bank.sv
// result registers a..d with holding byte for split reads
`timescale 1ns/1ns
module sas_result_bank (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_chan,
    input  wire logic [9:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data
);
    import sas_pkg::*;
    logic [9:0] result [4];
    logic [7:0] hold;
    // store completed result in its channel's register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) result[i] <= '0;
        end else if (wr_en) begin
            result[wr_chan] <= wr_data; // RL12 RL22
        end
    end
    // high byte read latches the low byte into the holding byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold <= 8'h00;
        end else if (rd_en && !rd_addr[0]) begin
            hold <= {result[rd_addr[2:1]][1:0], 6'h00}; // RL4 RL20
        end
    end
    // high byte direct, low byte from holding byte
    always_comb begin
        if (!rd_addr[0]) rd_data = result[rd_addr[2:1]][9:2]; // RL4 RL20
        else rd_data = hold; // RL5
    end
endmodule : sas_result_bank

// file: rtl/sas_sequencer.sv
// converter sequencer: control/status, trigger control, timing
`timescale 1ns/1ns
module sas_sequencer (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       standby,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [3:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    output logic            conv_end_irq,
    output logic            sample_strobe,
    output logic      [1:0] sample_chan,
    input  wire logic [9:0] approx_result
);
    import sas_pkg::*;

    // ==========================================================
    // timing windows used by the checks at the end
    localparam int SYNC_LO_S  = SYNC_SLOW;
    localparam int SYNC_HI_S  = SYNC_SLOW_MAX;
    localparam int SYNC_LO_F  = SYNC_FAST;
    localparam int SYNC_HI_F  = SYNC_FAST_MAX;
    localparam int FIRST_LO_S = FIRST_SLOW;
    localparam int FIRST_HI_S = FIRST_SLOW_MAX;
    localparam int FIRST_LO_F = FIRST_FAST;
    localparam int FIRST_HI_F = FIRST_FAST_MAX;

    // ==========================================================
    // state and address decode
    logic       init;
    logic       conv_end_flag, conv_end_irq_enable, conv_start, scan, conv_clock_select;
    logic [2:0] chan_sel;
    logic       ext_trigger_enable;
    logic       flag_seen;
    sas_state_t state;
    logic [8:0] cnt;
    logic [1:0] chan;
    logic       first;
    logic       done;
    logic       hit_status, hit_trig, hit_res;
    logic [7:0] res_rdata;
    logic [7:0] status_val;
    assign init = rst | standby;
    assign hit_status = bus_addr == OFS_STATUS;
    assign hit_trig = bus_addr == OFS_TRIGGER;
    assign hit_res = bus_addr < OFS_STATUS;
    assign status_val = {conv_end_flag, conv_end_irq_enable, conv_start, scan, conv_clock_select, chan_sel};

    // ==========================================================
    // helpers
    // step length of the conversion proper, per clock select
    // first step is trimmed so sync plus step gives the first-conversion total
    function automatic logic [8:0] step_len(input logic fast, input logic is_first);
        if (fast) step_len = is_first ? 9'(FIRST_FAST - SYNC_FAST) : 9'(CONV_FAST);
        else step_len = is_first ? 9'(FIRST_SLOW - SYNC_SLOW) : 9'(CONV_SLOW);
    endfunction : step_len
    // last channel of the active group
    function automatic logic [1:0] last_chan(input logic s, input logic [2:0] c);
        last_chan = s ? c[1:0] : c[1:0]; // RL21
    endfunction : last_chan

    // ==========================================================
    // registers written by software
    // trigger control register
    always_ff @(posedge core_clk) begin
        if (init) ext_trigger_enable <= TRIG_RESET[B_EXT_TRIGGER_ENABLE]; // RL1
        else if (bus_wr && hit_trig) ext_trigger_enable <= bus_wdata[B_EXT_TRIGGER_ENABLE]; // RL2 RL25
    end
    // control fields written by software
    always_ff @(posedge core_clk) begin
        if (init) begin
            conv_end_irq_enable <= STATUS_RESET[B_IRQEN];
            scan <= STATUS_RESET[B_SCAN];
            conv_clock_select <= STATUS_RESET[B_CKS];
            chan_sel <= STATUS_RESET[2:0];
        end else if (bus_wr && hit_status) begin
            conv_end_irq_enable <= bus_wdata[B_IRQEN];
            scan <= bus_wdata[B_SCAN]; // RL7
            conv_clock_select <= bus_wdata[B_CKS]; // RL23
            chan_sel <= bus_wdata[2:0]; // RL21
        end
    end

    // ==========================================================
    // end-of-conversion flag
    // end flag: set by hardware, cleared by read-then-write-0, set wins
    always_ff @(posedge core_clk) begin
        if (init) begin
            conv_end_flag <= 1'b0;
            flag_seen <= 1'b0;
        end else begin
            // a read that saw the flag arms the clear; any status write disarms it
            if (bus_rd && hit_status && conv_end_flag) flag_seen <= 1'b1; // RL10
            else if (bus_wr && hit_status) flag_seen <= 1'b0;
            if (done && (!scan || chan == last_chan(scan, chan_sel))) begin
                conv_end_flag <= 1'b1; // RL9 RL14
            end else if (bus_wr && hit_status && flag_seen && !bus_wdata[B_FLAG]) begin
                conv_end_flag <= 1'b0; // RL10
            end
        end
    end

    // ==========================================================
    // conversion sequencing
    // write edge loads the sync count; the strobe follows its expiry by one edge
    // later scan steps run the full step length back to back
    // a status write with start clear always wins and parks the sequencer
    // start bit and conversion sequencing
    always_ff @(posedge core_clk) begin
        if (init) begin
            conv_start <= 1'b0;
            state <= SAS_IDLE;
            cnt <= '0;
            chan <= '0;
            first <= 1'b0;
        end else if (bus_wr && hit_status && !bus_wdata[B_START]) begin
            conv_start <= 1'b0; // RL15
            state <= SAS_IDLE;
        end else if (bus_wr && hit_status && !conv_start) begin
            conv_start <= bus_wdata[B_START];
            state <= SAS_SYNC; // RL16
            cnt <= 9'(bus_wdata[B_CKS] ? SYNC_FAST - 1 : SYNC_SLOW - 1);
            chan <= bus_wdata[B_SCAN] ? 2'b00 : bus_wdata[1:0]; // RL13 RL15
            first <= 1'b1;
            if (!bus_wdata[B_START]) state <= SAS_IDLE;
        end else begin
            unique case (state)
                SAS_IDLE: cnt <= '0;
                SAS_SYNC: begin
                    if (cnt == 0) begin
                        state <= SAS_CONV; // RL17
                        cnt <= step_len(conv_clock_select, first) - 9'd1; // RL18
                    end else cnt <= cnt - 9'd1;
                end
                SAS_CONV: begin
                    if (cnt == 0) begin
                        first <= 1'b0;
                        if (!scan) begin
                            conv_start <= 1'b0; // RL8
                            state <= SAS_IDLE;
                        end else begin
                            chan <= (chan == last_chan(scan, chan_sel)) ? 2'b00 : chan + 2'd1;
                            cnt <= step_len(conv_clock_select, 1'b0) - 9'd1; // RL19
                        end
                    end else cnt <= cnt - 9'd1;
                end
                default: state <= SAS_IDLE;
            endcase
        end
    end
    assign done = state == SAS_CONV && cnt == 0 && conv_start;

    // ==========================================================
    // outputs to the analog side and the host
    // sample strobe marks the start of the sampling window
    always_ff @(posedge core_clk) begin
        if (init) sample_strobe <= 1'b0;
        else sample_strobe <= (state == SAS_SYNC && cnt == 0) || (done && scan); // RL24
    end
    assign sample_chan = chan;
    // interrupt request follows flag and enable
    always_ff @(posedge core_clk) begin
        if (init) conv_end_irq <= 1'b0;
        else conv_end_irq <= conv_end_flag & conv_end_irq_enable; // RL9 RL14
    end

    // ==========================================================
    // result storage
    // results land on the done edge; reads decode the low address bits
    sas_result_bank u_bank (
        .core_clk (core_clk),
        .rst      (init),
        .wr_en    (done),
        .wr_chan  (chan),
        .wr_data  (approx_result),
        .rd_en    (bus_rd && hit_res),
        .rd_addr  (bus_addr[2:0]),
        .rd_data  (res_rdata)
    );

    // ==========================================================
    // host read path
    // read mux; reserved trigger bits read as ones
    always_comb begin
        if (hit_res) bus_rdata = res_rdata;
        else if (hit_status) bus_rdata = status_val;
        else if (hit_trig) bus_rdata = {ext_trigger_enable, TRIG_RO_ONES[6:0]}; // RL3
        else bus_rdata = 8'h00;
    end

    // ==========================================================
    // checks
    // single conversion end clears the start bit and sets the end flag
    property p_single_clears;
        @(posedge core_clk) disable iff (init)
        (done && !scan && !bus_wr) |=> !conv_start && conv_end_flag;
    endproperty
    a_single_clears: assert property (p_single_clears) else $error("start not cleared"); // RL8
    property p_trig_ones;
        @(posedge core_clk) disable iff (init)
        hit_trig |-> bus_rdata[6:0] == 7'h7f;
    endproperty
    a_trig_ones: assert property (p_trig_ones) else $error("reserved bits not ones"); // RL3
    property p_irq;
        @(posedge core_clk) disable iff (init)
        (conv_end_flag && conv_end_irq_enable) |=> conv_end_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // RL9
    property p_scan_restart;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_status && !conv_start && bus_wdata[B_START] && bus_wdata[B_SCAN])
            |=> chan == 2'b00;
    endproperty
    a_scan_restart: assert property (p_scan_restart) else $error("scan not at ch0"); // RL15
    // slow start: sampling strobe inside the sync window
    property p_sync_slow;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_status && !conv_start && bus_wdata[B_START] && !bus_wdata[B_CKS])
            |-> ##[SYNC_LO_S:SYNC_HI_S] sample_strobe;
    endproperty
    a_sync_slow: assert property (p_sync_slow) else $error("slow sync delay out of range"); // RL16
    // fast start: sampling strobe inside the sync window
    property p_sync_fast;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_status && !conv_start && bus_wdata[B_START] && bus_wdata[B_CKS])
            |-> ##[SYNC_LO_F:SYNC_HI_F] sample_strobe;
    endproperty
    a_sync_fast: assert property (p_sync_fast) else $error("fast sync delay out of range"); // RL16
    // slow start: first conversion ends inside its window
    property p_first_slow;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_status && !conv_start && bus_wdata[B_START] && !bus_wdata[B_CKS])
            |-> ##[FIRST_LO_S:FIRST_HI_S] done;
    endproperty
    a_first_slow: assert property (p_first_slow) else $error("slow first conversion time"); // RL18
    // fast start: first conversion ends inside its window
    property p_first_fast;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_status && !conv_start && bus_wdata[B_START] && bus_wdata[B_CKS])
            |-> ##[FIRST_LO_F:FIRST_HI_F] done;
    endproperty
    a_first_fast: assert property (p_first_fast) else $error("fast first conversion time"); // RL18
    // later scan steps reload the full step length
    property p_step_len;
        @(posedge core_clk) disable iff (init)
        (done && scan && !bus_wr) |=> cnt == (conv_clock_select ? 9'(CONV_FAST - 1) : 9'(CONV_SLOW - 1));
    endproperty
    a_step_len: assert property (p_step_len) else $error("scan step length wrong"); // RL19
    // flag stays up until a write of zero
    property p_flag_hold;
        @(posedge core_clk) disable iff (init)
        (conv_end_flag && !(bus_wr && hit_status && !bus_wdata[B_FLAG])) |=> conv_end_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("end flag dropped"); // RL10
    // flag rises only at a conversion end
    property p_flag_set_only;
        @(posedge core_clk) disable iff (init)
        (!conv_end_flag && !done) |=> !conv_end_flag;
    endproperty
    a_flag_set_only: assert property (p_flag_set_only) else $error("end flag set early"); // RL9
    // no request while the enable is clear
    property p_irq_off;
        @(posedge core_clk) disable iff (init)
        !conv_end_irq_enable |=> !conv_end_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled"); // RL9
    // trigger enable bit is stored as written
    property p_trig_store;
        @(posedge core_clk) disable iff (init)
        (bus_wr && hit_trig) |=> ext_trigger_enable == $past(bus_wdata[B_EXT_TRIGGER_ENABLE]);
    endproperty
    a_trig_store: assert property (p_trig_store) else $error("trigger bit not stored"); // RL2 RL25
    // only a status write leaves idle
    property p_idle_hold;
        @(posedge core_clk) disable iff (init)
        (state == SAS_IDLE && !(bus_wr && hit_status)) |=> state == SAS_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("left idle without write"); // RL25
    // low result byte reads zeros below the two result bits
    property p_low_zero;
        @(posedge core_clk) disable iff (init)
        (hit_res && bus_addr[0]) |-> bus_rdata[5:0] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low byte filler not zero"); // RL20
    // reset and standby park everything
    property p_init_clear;
        @(posedge core_clk)
        init |=> (!conv_start && !conv_end_flag && state == SAS_IDLE && !ext_trigger_enable);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("init left state behind"); // RL1
endmodule : sas_sequencer

// file: tb/sas_analog_model.sv
// analog front end model: latches a code at each sample strobe
`timescale 1ns/1ns
module sas_analog_model (
    input  wire logic       core_clk,
    input  wire logic       sample_strobe,
    input  wire logic [9:0] next_code,
    output logic      [9:0] approx_result
);
    // code held from one strobe to the next
    initial approx_result = 10'h155;
    always @(posedge core_clk) begin
        if (sample_strobe) approx_result <= next_code;
    end
endmodule : sas_analog_model

// file: tb/sar_adc_sequencer_tb_top.sv
// testbench: bus tasks, strobe log model and conversion scenarios
`timescale 1ns/1ns
module sar_adc_sequencer_tb_top;
    import sas_pkg::*;
    logic       core_clk, rst, standby, bus_rd, bus_wr, conv_end_irq, sample_strobe;
    logic [3:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, st;
    logic [1:0] sample_chan, chan_q[$];
    logic [9:0] approx_result, next_code, val_q[$];
    logic [31:0] lfsr;
    int         err_count, cmp_count, cyc, wr_cyc, cv, sy, time_q[$];

    sas_sequencer sas_sequencer_i (.core_clk(core_clk), .rst(rst), .standby(standby),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .conv_end_irq(conv_end_irq), .sample_strobe(sample_strobe),
        .sample_chan(sample_chan), .approx_result(approx_result));
    sas_analog_model sas_analog_model_i (.core_clk(core_clk), .sample_strobe(sample_strobe),
        .next_code(next_code), .approx_result(approx_result));

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    // clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // cycle count and log of every sample strobe
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (sample_strobe === 1'b1) begin
            chan_q.push_back(sample_chan);
            val_q.push_back(next_code);
            time_q.push_back(cyc);
        end
    end
    // fresh random code for the analog model each cycle
    always @(negedge core_clk) begin
        lfsr      <= lfsr_step(lfsr);
        next_code <= lfsr[9:0];
    end
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk_rng(input logic [15:0] v, input int lo, input int hi);
        cmp_count++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t value %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask : chk_rng
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge core_clk);
        bus_addr  = a;
        bus_wdata = v;
        bus_wr    = 1'b1;
        @(negedge core_clk);
        bus_wr = 1'b0;
        wr_cyc = cyc;
    endtask : wr
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        @(negedge core_clk);
        bus_addr = a;
        bus_rd   = 1'b1;
        #1 v = bus_rdata;
        @(negedge core_clk);
        bus_rd = 1'b0;
        cmp_count++;
        if (v !== e) begin
            err_count++;
            $display("[FAIL] %0t read %h got %h want %h", $time, a, v, e);
        end
    endtask : chk_rd
    task automatic wait_irq();
        for (int i = 0; i < 1000 && conv_end_irq !== 1'b1; i++) @(negedge core_clk);
        chk_rng(conv_end_irq, 1, 1);
    endtask : wait_irq
    task automatic wait_strobes(input int n);
        for (int i = 0; i < 1000 && chan_q.size() < n; i++) @(negedge core_clk);
        chk_rng(chan_q.size(), n, n + 1);
    endtask : wait_strobes
    // watchdog
    initial begin
        #(4 * 20000);
        err_count++;
        tally_and_finish();
    end
    // ==========
    // main sequence
    initial begin
        {rst, standby, bus_rd, bus_wr, bus_addr, bus_wdata} = 16'h8000;
        {cyc, err_count, cmp_count, next_code, lfsr} = '0;
        lfsr = 32'hecd2;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        chk_rd(OFS_TRIGGER, TRIG_RESET);
        chk_rd(OFS_STATUS, STATUS_RESET);
        chk_rd(4'ha, 8'h00);
        wr(OFS_TRIGGER, 8'hff);
        chk_rd(OFS_TRIGGER, 8'hff);
        wr(OFS_TRIGGER, 8'h00);
        chk_rd(OFS_TRIGGER, TRIG_RO_ONES);
        // single conversions on every channel, clock select alternating
        for (int ch = 0; ch < 4; ch++) begin
            st = 8'h40 | 8'(ch) | (ch[0] ? 8'h08 : 8'h00);
            cv = ch[0] ? FIRST_FAST : FIRST_SLOW;
            sy = ch[0] ? SYNC_FAST : SYNC_SLOW;
            chan_q.delete();
            val_q.delete();
            time_q.delete();
            wr(OFS_STATUS, st | 8'h20);
            wait_strobes(1);
            chk_rng(time_q[0] - wr_cyc, sy, sy);
            chk_rng(chan_q[0], ch, ch);
            chk_rd(OFS_STATUS, st | 8'h20);
            wait_irq();
            chk_rng(cyc - wr_cyc, cv, cv + 2);
            wr(OFS_STATUS, st);
            chk_rd(OFS_STATUS, st | 8'h80);
            wr(OFS_STATUS, st);
            chk_rd(OFS_STATUS, st);
            chk_rng(conv_end_irq === 1'b1, 0, 0);
            chk_rd(4'(2 * ch), val_q[0][9:2]);
            chk_rd(4'(2 * ch + 1), {val_q[0][1:0], 6'h00});
        end
        // scan group 0..2 on the fast clock, then stop and restart
        chan_q.delete();
        val_q.delete();
        time_q.delete();
        wr(OFS_STATUS, 8'h7a);
        wait_irq();
        wait_strobes(4);
        for (int i = 0; i < 4; i++) chk_rng(chan_q[i], i % 3, i % 3);
        for (int i = 1; i < 3; i++) chk_rng(time_q[i+1] - time_q[i], CONV_FAST, CONV_FAST);
        for (int i = 0; i < 3; i++) begin
            chk_rd(4'(2 * i), val_q[i][9:2]);
            chk_rd(4'(2 * i + 1), {val_q[i][1:0], 6'h00});
        end
        chk_rd(4'h4, val_q[2][9:2]);
        chk_rd(4'h3, {val_q[2][1:0], 6'h00});
        chk_rd(OFS_STATUS, 8'hfa);
        wr(OFS_STATUS, 8'h5a);
        chk_rd(OFS_STATUS, 8'h5a);
        chan_q.delete();
        wr(OFS_STATUS, 8'h7a);
        wait_strobes(1);
        chk_rng(chan_q[0], 0, 0);
        // standby clears everything like reset
        wr(OFS_TRIGGER, 8'h80);
        @(negedge core_clk);
        standby = 1'b1;
        @(negedge core_clk);
        standby = 1'b0;
        chk_rd(OFS_TRIGGER, TRIG_RESET);
        chk_rd(OFS_STATUS, STATUS_RESET);
        chk_rd(OFS_RES_A_HI, 8'h00);
        tally_and_finish();
    end
endmodule : sar_adc_sequencer_tb_top
